// ---- verilog/msx_alu_defines.vh ----
// Opcode encodings, operand widths, nibble bounds and reset values for the sub/xor/swap datapath.
`ifndef MSX_ALU_DEFINES_VH
`define MSX_ALU_DEFINES_VH
`define MSX_OP_W           3
`define MSX_OP_NONE        3'h0
`define MSX_OP_SUB_LIT     3'h1
`define MSX_OP_SUB_REG     3'h2
`define MSX_OP_XOR_REG     3'h3
`define MSX_OP_SWAP        3'h4
`define MSX_OP_XOR_LIT     3'h5
`define MSX_DATA_W         8
`define MSX_ADDR_W         7
`define MSX_DEST_ACC       1'h0
`define MSX_DEST_REG       1'h1
`define MSX_ACC_RESET      8'h00
`define MSX_FLAG_RESET     1'h0
`define MSX_LOW_NIB_HI     3
`define MSX_HIGH_NIB_LO    4
`endif

// ---- verilog/msx_alu.v ----
// Sub/xor/swap slice of an 8-bit core datapath with accumulator and status flags.
`timescale 1ns/1ps
`default_nettype none
`include "msx_alu_defines.vh"

module msx_alu #(
    parameter DATA_W = `MSX_DATA_W,
    parameter ADDR_W = `MSX_ADDR_W
) (
    input  wire              core_clk,     // Core clock, 100 MHz.
    input  wire              arst_n,       // Asynchronous reset, active low.
    input  wire              op_valid,     // One-cycle pulse: execute op_code this cycle.
    input  wire [2:0]        op_code,      // Operation select.
    input  wire [DATA_W-1:0] literal,      // 8-bit literal operand.
    input  wire [ADDR_W-1:0] reg_addr,     // File register address, 0 to 127.
    input  wire              dest_sel,     // Destination: 0 accumulator, 1 register.
    input  wire [DATA_W-1:0] reg_rdata,    // Contents of the addressed register.
    output reg  [DATA_W-1:0] acc,          // Accumulator.
    output reg               carry_flag,   // Carry / not-borrow.
    output reg               half_carry_flag, // Low-nibble carry / not-borrow.
    output reg               zero_flag,    // Result was zero.
    output reg               reg_we,       // One-cycle write strobe to the register file.
    output reg  [ADDR_W-1:0] reg_waddr,    // Register write address.
    output reg  [DATA_W-1:0] reg_wdata     // Register write data.
);

    // Decoded operation class.
    reg               is_sub;
    reg               is_xor;
    reg               is_swap;
    reg               uses_lit;
    reg               dest_ok;
    wire              exec;
    wire              to_reg;

    // Shared operand and arithmetic results.
    wire [DATA_W-1:0] operand;
    wire [DATA_W-1:0] sub_result;
    wire              sub_no_borrow;
    wire              low_no_borrow;
    wire [DATA_W-1:0] xor_result;
    wire [DATA_W-1:0] swap_result;
    reg  [DATA_W-1:0] result;
    wire              result_zero;

    // Next state of every output flop.
    reg  [DATA_W-1:0] next_acc;
    reg               next_carry_flag;
    reg               next_half_carry_flag;
    reg               next_zero_flag;
    reg               next_reg_we;
    reg  [ADDR_W-1:0] next_reg_waddr;
    reg  [DATA_W-1:0] next_reg_wdata;

    always @* begin
        is_sub   = 1'b0;
        is_xor   = 1'b0;
        is_swap  = 1'b0;
        uses_lit = 1'b0;
        dest_ok  = 1'b0;
        case (op_code)
            `MSX_OP_SUB_LIT: begin
                is_sub   = 1'b1;
                uses_lit = 1'b1;
            end
            `MSX_OP_SUB_REG: begin
                is_sub  = 1'b1;
                dest_ok = 1'b1;
            end
            `MSX_OP_XOR_REG: begin
                is_xor  = 1'b1;
                dest_ok = 1'b1;
            end
            `MSX_OP_SWAP: begin
                is_swap = 1'b1;
                dest_ok = 1'b1;
            end
            `MSX_OP_XOR_LIT: begin
                is_xor   = 1'b1;
                uses_lit = 1'b1;
            end
            default: begin
                // Unused codes decode to nothing, so a stray strobe changes no state.
                is_sub = 1'b0;
            end
        endcase
    end

    // Literal forms always return to the accumulator, whatever dest_sel says.
    assign exec   = op_valid && (is_sub || is_xor || is_swap);
    assign to_reg = dest_ok && (dest_sel == `MSX_DEST_REG);

    // One operand mux feeds the subtractors, the xor and the swap alike.
    assign operand = uses_lit ? literal : reg_rdata;

    // Full-width subtractor: no borrow out means the accumulator was not larger.
    msx_sub_borrow #(
        .W (DATA_W)
    ) i_sub_full (
        .minuend    (operand),
        .subtrahend (acc),
        .diff       (sub_result),
        .no_borrow  (sub_no_borrow)
    );

    // A separate nibble subtractor costs a few gates but needs no tap inside the wide one.
    msx_sub_borrow #(
        .W (`MSX_LOW_NIB_HI + 1)
    ) i_sub_low (
        .minuend    (operand[`MSX_LOW_NIB_HI:0]),
        .subtrahend (acc[`MSX_LOW_NIB_HI:0]),
        .diff       (),
        .no_borrow  (low_no_borrow)
    );

    assign xor_result  = acc ^ operand;
    assign swap_result = {operand[`MSX_LOW_NIB_HI:0],
                          operand[DATA_W-1:`MSX_HIGH_NIB_LO]};

    always @* begin
        if (is_sub) begin
            result = sub_result;
        end else if (is_xor) begin
            result = xor_result;
        end else begin
            result = swap_result;
        end
    end

    assign result_zero = (result == {DATA_W{1'b0}});

    always @* begin
        next_acc             = acc;
        next_carry_flag      = carry_flag;
        next_half_carry_flag = half_carry_flag;
        next_zero_flag       = zero_flag;
        next_reg_we          = 1'b0;
        next_reg_waddr       = reg_waddr;
        next_reg_wdata       = reg_wdata;
        if (exec) begin
            if (to_reg) begin
                next_reg_we    = 1'b1;
                next_reg_waddr = reg_addr;
                next_reg_wdata = result;
            end else begin
                next_acc = result;
            end
            if (is_sub) begin
                next_carry_flag      = sub_no_borrow;
                next_half_carry_flag = low_no_borrow;
            end
            // Swap must leave status intact so software can save it without disturbing it.
            if (!is_swap) begin
                next_zero_flag = result_zero;
            end
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc             <= `MSX_ACC_RESET;
            carry_flag      <= `MSX_FLAG_RESET;
            half_carry_flag <= `MSX_FLAG_RESET;
            zero_flag       <= `MSX_FLAG_RESET;
            reg_we          <= 1'b0;
            reg_waddr       <= {ADDR_W{1'b0}};
            reg_wdata       <= {DATA_W{1'b0}};
        end else begin
            acc             <= next_acc;
            carry_flag      <= next_carry_flag;
            half_carry_flag <= next_half_carry_flag;
            zero_flag       <= next_zero_flag;
            reg_we          <= next_reg_we;
            reg_waddr       <= next_reg_waddr;
            reg_wdata       <= next_reg_wdata;
        end
    end

endmodule

// Unsigned subtractor that also reports whether the subtrahend did not exceed the minuend.
module msx_sub_borrow #(
    parameter W = 8
) (
    input  wire [W-1:0] minuend,    // Value subtracted from.
    input  wire [W-1:0] subtrahend, // Value subtracted.
    output wire [W-1:0] diff,       // Difference modulo two to the W.
    output wire         no_borrow   // High when subtrahend <= minuend.
);

    wire [W:0] ext;

    assign ext       = {1'b0, minuend} - {1'b0, subtrahend};
    assign diff      = ext[W-1:0];
    assign no_borrow = ~ext[W];

endmodule
`default_nettype wire

// ---- dv/msx_alu_checker.sv ----
// Port assertions for the sub/xor/swap datapath.
`timescale 1ns/1ps
`default_nettype none
module msx_alu_checker (
    input wire core_clk, arst_n, op_valid, dest_sel, reg_we,
    input wire carry_flag, half_carry_flag, zero_flag,
    input wire [2:0] op_code,
    input wire [7:0] literal, reg_rdata, acc, reg_wdata,
    input wire [6:0] reg_addr, reg_waddr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire [7:0] go = op_valid ? 8'h01 << op_code : 8'h00;
    wire [7:0] res = reg_we ? reg_wdata : acc;
    wire [2:0] flags = {carry_flag, half_carry_flag, zero_flag};
    AST_SUB_LIT: assert property (go[1] |=>
        acc == $past(literal - acc) && !reg_we
        && carry_flag == ($past(acc) <= $past(literal))
        && half_carry_flag == ($past(acc[3:0]) <= $past(literal[3:0])))
        else $error("sub literal");
    AST_BORROW: assert property (go[2] |=>
        carry_flag == ($past(acc) <= $past(reg_rdata))
        && half_carry_flag == ($past(acc[3:0]) <= $past(reg_rdata[3:0])))
        else $error("borrow");
    AST_SUB_REG: assert property (go[2] |=>
        reg_we == $past(dest_sel) && res == $past(reg_rdata - acc)
        && (reg_we ? reg_waddr == $past(reg_addr) : $stable(reg_waddr)))
        else $error("sub reg");
    AST_XOR_REG: assert property (go[3] |=>
        reg_we == $past(dest_sel) && res == $past(reg_rdata ^ acc)
        && $stable(carry_flag) && $stable(half_carry_flag))
        else $error("xor reg");
    AST_SWAP: assert property (go[4] |=>
        res == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])}
        && reg_we == $past(dest_sel) && $stable(flags))
        else $error("swap");
    AST_XOR_LIT: assert property (go[5] |=>
        acc == $past(literal ^ acc) && !reg_we && $stable(carry_flag))
        else $error("xor lit");
    AST_ZERO: assert property (go[1] || go[2] || go[3] || go[5] |=>
        zero_flag == (res == 8'h00))
        else $error("zero flag");
    AST_IDLE: assert property ((!op_valid || op_code == 3'h0 || op_code > 3'h5) |=>
        !reg_we && $stable(acc) && $stable(flags))
        else $error("idle change");
endmodule
bind msx_alu msx_alu_checker i_msx_alu_checker (.*);
`default_nettype wire

// ---- dv/msx_alu_tb.sv ----
// Self-checking bench for the sub/xor/swap datapath.
`timescale 1ns/1ps
`default_nettype none
module msx_alu_tb;
    reg core_clk = 0, arst_n = 0, op_valid = 0, dest_sel = 0;
    reg [2:0] op_code = 3'h0;
    reg [7:0] literal = 8'h00, reg_rdata = 8'h00;
    reg [6:0] reg_addr = 7'h00;
    wire [7:0] acc, reg_wdata;
    wire [6:0] reg_waddr;
    wire carry_flag, half_carry_flag, zero_flag, reg_we;
    integer errors = 0, checks = 0, cyc = 0;
    msx_alu i_msx_alu (
        .core_clk        (core_clk),
        .arst_n          (arst_n),
        .op_valid        (op_valid),
        .op_code         (op_code),
        .literal         (literal),
        .reg_addr        (reg_addr),
        .dest_sel        (dest_sel),
        .reg_rdata       (reg_rdata),
        .acc             (acc),
        .carry_flag      (carry_flag),
        .half_carry_flag (half_carry_flag),
        .zero_flag       (zero_flag),
        .reg_we          (reg_we),
        .reg_waddr       (reg_waddr),
        .reg_wdata       (reg_wdata)
    );
    always #5 core_clk = ~core_clk;
    task give_verdict;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task check(input [26:0] seen, input [26:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[FAIL] %0t result mismatch, seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Expected: write address, then acc, reg_wdata, carry, half carry, zero, write strobe.
    task op(input [2:0] c, input [7:0] k, input d, input [6:0] wa, input [19:0] exp);
        begin
            @(posedge core_clk);
            {op_valid, op_code, literal, reg_rdata, reg_addr, dest_sel} <= {1'b1, c, k, k, k[6:0], d};
            @(posedge core_clk);
            op_valid <= 1'b0;
            #1;
            check({reg_waddr, acc, reg_wdata, carry_flag, half_carry_flag, zero_flag, reg_we},
                  {wa, exp});
        end
    endtask
    task t_sub;
        begin
            op(3'h5, 8'h03, 1'b0, 7'h00, 20'h03000);
            op(3'h2, 8'h05, 1'b1, 7'h05, 20'h0302d);
            op(3'h1, 8'h02, 1'b0, 7'h05, 20'hff020);
            op(3'h1, 8'hff, 1'b0, 7'h05, 20'h0002e);
        end
    endtask
    task t_xor_swap;
        begin
            op(3'h3, 8'h0f, 1'b0, 7'h05, 20'h0f02c);
            op(3'h4, 8'ha5, 1'b1, 7'h25, 20'h0f5ad);
            op(3'h3, 8'h0f, 1'b1, 7'h0f, 20'h0f00f);
            op(3'h5, 8'h0f, 1'b0, 7'h0f, 20'h0000e);
            op(3'h6, 8'h55, 1'b1, 7'h0f, 20'h0000e);
            op(3'h5, 8'h0f, 1'b0, 7'h0f, 20'h0f00c);
            op(3'h1, 8'h10, 1'b0, 7'h0f, 20'h01008);
            op(3'h2, 8'h0e, 1'b0, 7'h0f, 20'h0d00c);
            op(3'h4, 8'h3c, 1'b0, 7'h0f, 20'hc300c);
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 500) begin
            errors = errors + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        t_sub;
        t_xor_swap;
        give_verdict;
    end
endmodule
`default_nettype wire
